// ===== hdl/lcm_regs.sv
// line clock, pin mux, interrupt mask, sync status and statistics registers
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1 - line clock 1 pin is input while its enable bit is 0, driven when 1
// R2 - line clock 2 pin is input while its enable bit is 0, driven when 1
// R3 - line clock 3 pin is input while its enable bit is 0, driven when 1
// R4 - rate field picks 2.048, 4.096, 8.192 or 16.384 MHz for driven clock
// R5 - rate field has no effect while the line clock is an input
// R6 - unused bits of every register read as zero
// R7 - subscriber mux bit hands subscriber pins to hdlc channel 1 when set
// R8 - first pcm mux bit hands pcm ports 0 and 2 to channel 2
// R9 - second pcm mux bit hands pcm ports 1 and 3 to channel 3
// R10 - interrupt mask bit blocks the hdlc interrupt at 0, passes at 1
// R11 - secondary frame sync rising edge sets bit 2, core read clears it
// R12 - frame sync rising edge sets bit 1, core read clears it
// R13 - bit 0 set once both edge bits are set, core read clears it
// R14 - frame sync clears counter only if core read it since last sync
// R15 - chip reset leaves the statistics counter untouched
// R16 - core writes the 8-bit maximum count into write-only limit register
// R17 - hdlc channels 1 to 3 usable only while their mux bit is set
// R18 - sync edge in the cycle of a status read keeps its bit set
// R19 - hdlc interrupt out is channel request and mask bit together
module lcm_regs #(
  parameter int STAT_W = lcm_pkg::LCM_STAT_W // statistics counter width
) (
  input wire logic clock, // core clock, 10 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [15:0] reg_addr, // core register address
  input wire logic reg_wr, // core write strobe, one cycle
  input wire logic reg_rd, // core read strobe, one cycle
  input wire logic [15:0] reg_wdata, // core write data
  output var logic [15:0] reg_rdata, // read data, one cycle after strobe
  output var logic reg_rvalid, // read data valid pulse
  input wire logic frame_sync, // frame sync pin, asynchronous
  input wire logic secondary_frame_sync, // secondary sync pin, asynchronous
  input wire logic hdlc_irq_req, // channel interrupt request, same clock
  input wire logic stat_event, // statistics count event, same clock
  output var logic hdlc_irq, // masked hdlc interrupt to the core
  output var logic [2:0] line_clk_oe, // line clock 3..1 pad output enables
  output var logic [5:0] line_clk_rate, // line clock 3..1 rate codes
  output var logic subscriber_pin_select, // subscriber pins to channel 1
  output var logic pcm02_pin_select, // pcm ports 0 and 2 to channel 2
  output var logic pcm13_pin_select, // pcm ports 1 and 3 to channel 3
  output var logic [2:0] generic_hdlc_channel_en, // channels 3..1 reachable
  output var logic stat_at_max // counter has reached its limit
);

  // refuse counter widths the 16-bit registers cannot hold
  if (STAT_W < 1 || STAT_W > lcm_pkg::LCM_REG_W) begin : g_bad_width
    $error("lcm_regs: STAT_W must lie between 1 and 16");
  end

  typedef struct packed {
    logic irq_en;
    logic [2:0] mux;
    logic [2:0] ch_en;
    logic sfs_seen;
    logic fs_seen;
    logic both_seen;
    logic [STAT_W-1:0] count;
    logic [STAT_W-1:0] count_max;
    logic read_since_fs;
    logic at_max;
    logic [15:0] rdata;
    logic rvalid;
    logic irq;
  } lcm_regs_st_t;

  lcm_regs_st_t st_q;
  lcm_regs_st_t st_d;

  logic fs_rise;
  logic sfs_rise;
  logic [2:0] lclk_wr;
  logic [8:0] lclk_ctl;

  // address decode for writes and reads
  logic wr_mask;
  logic wr_count;
  logic wr_limit;
  logic wr_mux;
  logic rd_status;
  logic rd_count;

  assign wr_mask = reg_wr && (reg_addr == lcm_pkg::LCM_OFS_IRQ_MASK);
  assign wr_count = reg_wr && (reg_addr == lcm_pkg::LCM_OFS_STAT_COUNT);
  assign wr_limit = reg_wr && (reg_addr == lcm_pkg::LCM_OFS_STAT_LIMIT);
  assign wr_mux = reg_wr && (reg_addr == lcm_pkg::LCM_OFS_PIN_MUX);
  assign rd_status = reg_rd && (reg_addr == lcm_pkg::LCM_OFS_SYNC_STATUS);
  assign rd_count = reg_rd && (reg_addr == lcm_pkg::LCM_OFS_STAT_COUNT);

  // line clock control writes, one strobe each
  assign lclk_wr[0] = reg_wr && (reg_addr == lcm_pkg::LCM_OFS_LCLK1_CTRL);
  assign lclk_wr[1] = reg_wr && (reg_addr == lcm_pkg::LCM_OFS_LCLK2_CTRL);
  assign lclk_wr[2] = reg_wr && (reg_addr == lcm_pkg::LCM_OFS_LCLK3_CTRL);

  // sync pins cross into the core clock before edge detection
  lcm_sync_edge u_fs_edge (
    .clock(clock),
    .rst(rst),
    .pin_in(frame_sync),
    .rise_q(fs_rise)
  );

  lcm_sync_edge u_sfs_edge (
    .clock(clock),
    .rst(rst),
    .pin_in(secondary_frame_sync),
    .rise_q(sfs_rise)
  );

  // one control register and pad steer per line clock
  for (genvar i = 0; i < lcm_pkg::LCM_LCLK_NUM; i++) begin : g_lclk
    // R1 R2 R3 per-line direction control
    lcm_line_clk_ctl u_ctl (
      .clock(clock),
      .rst(rst),
      .wr_en(lclk_wr[i]),
      .wr_data(reg_wdata[lcm_pkg::LCM_LCLK_CTRL_W-1:0]),
      .ctl_q(lclk_ctl[i*3 +: 3]),
      .pad_oe_q(line_clk_oe[i]),
      .pad_rate_q(line_clk_rate[i*2 +: 2])
    );
  end

  // next-state logic for all registers of this bank except the three line clock controls
  always_comb begin
    logic fs_next;
    logic sfs_next;
    logic [STAT_W-1:0] cnt;
    fs_next = 1'b0;
    sfs_next = 1'b0;
    cnt = '0;
    st_d = st_q;

    // R10 mask register write
    if (wr_mask) begin
      st_d.irq_en = reg_wdata[lcm_pkg::LCM_IRQ_EN_BIT];
    end

    // pin mux register write
    if (wr_mux) begin
      st_d.mux = reg_wdata[lcm_pkg::LCM_MUX_W-1:0];
    end

    // R17 channel reach follows the mux bits
    st_d.ch_en = st_q.mux;

    // R16 write-only maximum count
    if (wr_limit) begin
      st_d.count_max = reg_wdata[STAT_W-1:0];
    end

    // R12 frame sync edge sets, read clears
    // R18 an edge in the read cycle wins
    fs_next = (st_q.fs_seen && !rd_status) || fs_rise;
    // R11 secondary sync edge sets, read clears
    sfs_next = (st_q.sfs_seen && !rd_status) || sfs_rise;
    st_d.fs_seen = fs_next;
    st_d.sfs_seen = sfs_next;
    // R13 both bits seen together
    st_d.both_seen = (st_q.both_seen && !rd_status) || (fs_next && sfs_next);

    // counter: core write, then frame clear, then counting
    cnt = st_q.count;
    if (wr_count) begin
      cnt = reg_wdata[STAT_W-1:0];
    end else if (fs_rise && st_q.read_since_fs) begin
      // R14 clear only after a core read
      cnt = '0;
    end else if (stat_event && (st_q.count < st_q.count_max)) begin
      // saturate at the programmed limit rather than wrap
      cnt = st_q.count + 1'b1;
    end
    st_d.count = cnt;
    st_d.at_max = (cnt == st_q.count_max);

    // a read in the sync cycle counts for the next interval
    if (rd_count) begin
      st_d.read_since_fs = 1'b1;
    end else if (fs_rise) begin
      st_d.read_since_fs = 1'b0;
    end

    // R19 masked interrupt
    st_d.irq = hdlc_irq_req && st_q.irq_en;

    // read data, registered one cycle after the strobe
    st_d.rvalid = reg_rd;
    if (reg_rd) begin
      // R6 unused bits and unmapped addresses read zero
      st_d.rdata = lcm_pkg::LCM_RST_VAL;
      case (reg_addr)
        lcm_pkg::LCM_OFS_IRQ_MASK: begin
          st_d.rdata[lcm_pkg::LCM_IRQ_EN_BIT] = st_q.irq_en;
        end
        lcm_pkg::LCM_OFS_SYNC_STATUS: begin
          st_d.rdata[lcm_pkg::LCM_ST_BOTH_BIT] = st_q.both_seen;
          st_d.rdata[lcm_pkg::LCM_ST_FS_BIT] = st_q.fs_seen;
          st_d.rdata[lcm_pkg::LCM_ST_SFS_BIT] = st_q.sfs_seen;
        end
        lcm_pkg::LCM_OFS_STAT_COUNT: begin
          st_d.rdata[STAT_W-1:0] = st_q.count;
        end
        lcm_pkg::LCM_OFS_LCLK1_CTRL: begin
          st_d.rdata[2:0] = lclk_ctl[2:0];
        end
        lcm_pkg::LCM_OFS_LCLK2_CTRL: begin
          st_d.rdata[2:0] = lclk_ctl[5:3];
        end
        lcm_pkg::LCM_OFS_LCLK3_CTRL: begin
          st_d.rdata[2:0] = lclk_ctl[8:6];
        end
        lcm_pkg::LCM_OFS_PIN_MUX: begin
          st_d.rdata[lcm_pkg::LCM_MUX_W-1:0] = st_q.mux;
        end
        default: begin
          // limit register is write-only and reads zero
          st_d.rdata = lcm_pkg::LCM_RST_VAL;
        end
      endcase
    end

    // R15 chip reset clears the bank but leaves the counter as it was
    // folded in here so the flop never needs a reset branch that reads state
    if (rst) begin
      st_d = '0;
      st_d.count_max = STAT_W'(lcm_pkg::LCM_STAT_MAX_RST);
      st_d.count = st_q.count;
    end
  end

  // state register, synchronous reset already folded into the next value
  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  // outputs straight from the state register
  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign hdlc_irq = st_q.irq;
  // R7 subscriber pins to channel 1
  assign subscriber_pin_select = st_q.mux[lcm_pkg::LCM_MUX_SUBSCR_BIT];
  // R8 pcm 0 and 2 to channel 2
  assign pcm02_pin_select = st_q.mux[lcm_pkg::LCM_MUX_PCM02_BIT];
  // R9 pcm 1 and 3 to channel 3
  assign pcm13_pin_select = st_q.mux[lcm_pkg::LCM_MUX_PCM13_BIT];
  assign generic_hdlc_channel_en = st_q.ch_en;
  assign stat_at_max = st_q.at_max;

endmodule : lcm_regs

`default_nettype wire

// ===== include/lcm_pkg.sv
// constants for the line clock, pin mux and frame status register bank
package lcm_pkg;

  // register offsets on the core register port
  localparam logic [15:0] LCM_OFS_IRQ_MASK = 16'hD002;
  localparam logic [15:0] LCM_OFS_SYNC_STATUS = 16'hD003;
  localparam logic [15:0] LCM_OFS_STAT_COUNT = 16'hD004;
  localparam logic [15:0] LCM_OFS_STAT_LIMIT = 16'hD005;
  localparam logic [15:0] LCM_OFS_LCLK1_CTRL = 16'hD08B;
  localparam logic [15:0] LCM_OFS_LCLK2_CTRL = 16'hD08C;
  localparam logic [15:0] LCM_OFS_LCLK3_CTRL = 16'hD08D;
  localparam logic [15:0] LCM_OFS_PIN_MUX = 16'hD14A;

  // register width shared by all registers, reset value shared by all but the statistics counter
  localparam int LCM_REG_W = 16;
  localparam logic [15:0] LCM_RST_VAL = 16'h0000;

  // line clock control fields
  localparam int LCM_LCLK_NUM = 3;
  localparam int LCM_LCLK_RATE_LSB = 0;
  localparam int LCM_LCLK_RATE_W = 2;
  localparam int LCM_LCLK_OE_BIT = 2;
  localparam int LCM_LCLK_CTRL_W = 3;

  // rate codes for a driven line clock
  localparam logic [1:0] LCM_RATE_2M048 = 2'h0;
  localparam logic [1:0] LCM_RATE_4M096 = 2'h1;
  localparam logic [1:0] LCM_RATE_8M192 = 2'h2;
  localparam logic [1:0] LCM_RATE_16M384 = 2'h3;

  // pin mux control fields
  localparam int LCM_MUX_SUBSCR_BIT = 0;
  localparam int LCM_MUX_PCM02_BIT = 1;
  localparam int LCM_MUX_PCM13_BIT = 2;
  localparam int LCM_MUX_W = 3;

  // interrupt mask field
  localparam int LCM_IRQ_EN_BIT = 0;

  // sync status fields
  localparam int LCM_ST_BOTH_BIT = 0;
  localparam int LCM_ST_FS_BIT = 1;
  localparam int LCM_ST_SFS_BIT = 2;

  // statistics fields
  localparam int LCM_STAT_W = 8;
  localparam logic [7:0] LCM_STAT_MAX_RST = 8'h00;

endpackage : lcm_pkg

// ===== hdl/lcm_sync_edge.sv
// two-flop synchroniser for a pin with a registered rising-edge pulse
`timescale 1ns/1ps
`default_nettype none

module lcm_sync_edge (
  input wire logic clock, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic pin_in, // asynchronous pin level
  output var logic rise_q // one-cycle pulse on a rising edge
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic rise;
  } lcm_sync_st_t;

  lcm_sync_st_t st_q;
  lcm_sync_st_t st_d;

  // meta is read only by sync, the detector looks at sync and last
  always_comb begin
    st_d = st_q;
    st_d.meta = pin_in;
    st_d.sync = st_q.meta;
    st_d.last = st_q.sync;
    st_d.rise = st_q.sync & ~st_q.last;
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise_q = st_q.rise;

endmodule : lcm_sync_edge

`default_nettype wire

// ===== hdl/lcm_line_clk_ctl.sv
// control register and pad steering for one line clock
`timescale 1ns/1ps
`default_nettype none

module lcm_line_clk_ctl (
  input wire logic clock, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic wr_en, // write strobe for this register
  input wire logic [2:0] wr_data, // output enable and rate bits
  output var logic [2:0] ctl_q, // stored register bits
  output var logic pad_oe_q, // high while the pin is driven
  output var logic [1:0] pad_rate_q // rate handed to the clock pad
);

  typedef struct packed {
    logic [2:0] ctl;
    logic oe;
    logic [1:0] rate;
  } lcm_lclk_st_t;

  lcm_lclk_st_t st_q;
  lcm_lclk_st_t st_d;

  // register update and pad steering
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      st_d.ctl = wr_data;
    end
    // R1 pin direction from enable
    st_d.oe = st_q.ctl[lcm_pkg::LCM_LCLK_OE_BIT];
    // R5 rate ignored when input
    if (st_q.ctl[lcm_pkg::LCM_LCLK_OE_BIT]) begin
      // R4 rate code selection
      st_d.rate = st_q.ctl[lcm_pkg::LCM_LCLK_RATE_LSB +: lcm_pkg::LCM_LCLK_RATE_W];
    end else begin
      st_d.rate = lcm_pkg::LCM_RATE_2M048;
    end
  end

  // state register, all fields return to zero
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ctl_q = st_q.ctl;
  assign pad_oe_q = st_q.oe;
  assign pad_rate_q = st_q.rate;

endmodule : lcm_line_clk_ctl

`default_nettype wire

// ===== dv/lcm_chk.sv
// port assertions for the line clock, pin mux and status register bank
`timescale 1ns/1ps
`default_nettype none

module lcm_chk #(
  parameter int STAT_W = 8 // counter width
) (
  input wire logic clock, // core clock
  input wire logic rst, // sync reset
  input wire logic [15:0] reg_addr, // address
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_wdata, // write data
  input wire logic [15:0] reg_rdata, // read data
  input wire logic reg_rvalid, // read valid
  input wire logic hdlc_irq_req, // channel request
  input wire logic hdlc_irq, // masked irq
  input wire logic [2:0] line_clk_oe, // pad enables
  input wire logic [5:0] line_clk_rate, // pad rates
  input wire logic subscriber_pin_select, // mux bit 0
  input wire logic pcm02_pin_select, // mux bit 1
  input wire logic pcm13_pin_select, // mux bit 2
  input wire logic [2:0] generic_hdlc_channel_en // channels 3..1
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // a lone write to line clock 1, so the pad value two edges on is unambiguous
  sequence s_lclk1_wr;
    reg_wr && reg_addr == lcm_pkg::LCM_OFS_LCLK1_CTRL
      ##1 !(reg_wr && reg_addr == lcm_pkg::LCM_OFS_LCLK1_CTRL);
  endsequence
  // status read whose answer shows the both-seen bit
  sequence s_both_rd;
    reg_rd && reg_addr == lcm_pkg::LCM_OFS_SYNC_STATUS ##1 reg_rdata[0];
  endsequence

  a_lclk1_write: assert property (s_lclk1_wr |=>
    line_clk_oe[0] == $past(reg_wdata[2], 2) &&
    line_clk_rate[1:0] == ($past(reg_wdata[2], 2) ? $past(reg_wdata[1:0], 2) : 2'h0))
    else $error("line clock 1 pad does not follow its write");
  a_rate_input: assert property ((line_clk_oe[1] || line_clk_rate[3:2] == 2'h0) &&
    (line_clk_oe[2] || line_clk_rate[5:4] == 2'h0))
    else $error("rate reaches a pad that is an input");
  a_irq_cause: assert property (hdlc_irq |-> $past(hdlc_irq_req))
    else $error("interrupt without a channel request");
  a_unused_zero: assert property (reg_rvalid |-> reg_rdata[15:8] == 8'h00)
    else $error("unused read bits not zero");
  a_mux_write: assert property (reg_wr && reg_addr == lcm_pkg::LCM_OFS_PIN_MUX |=>
    {pcm13_pin_select, pcm02_pin_select, subscriber_pin_select} == $past(reg_wdata[2:0]))
    else $error("mux outputs do not follow the write");
  a_chan_follow: assert property (generic_hdlc_channel_en ==
    $past({pcm13_pin_select, pcm02_pin_select, subscriber_pin_select}))
    else $error("channel enables do not follow the mux bits");
  a_rst_quiet: assert property ($fell(rst) |-> line_clk_oe == 3'h0 && !hdlc_irq)
    else $error("outputs not at reset value");
  a_both_seen: assert property (s_both_rd |-> reg_rdata[2:1] == 2'h3)
    else $error("both-seen set without both edges");
endmodule : lcm_chk

bind lcm_regs lcm_chk #(.STAT_W(STAT_W)) u_lcm_chk (.clock(clock), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .hdlc_irq_req(hdlc_irq_req),
  .hdlc_irq(hdlc_irq), .line_clk_oe(line_clk_oe), .line_clk_rate(line_clk_rate),
  .subscriber_pin_select(subscriber_pin_select), .pcm02_pin_select(pcm02_pin_select),
  .pcm13_pin_select(pcm13_pin_select), .generic_hdlc_channel_en(generic_hdlc_channel_en));
`default_nettype wire

// ===== dv/lcm_sync_src.sv
// far side model: line equipment driving the two frame sync pins
`timescale 1ns/1ps
`default_nettype none

module lcm_sync_src (
  input wire logic clock, // core clock
  output var logic frame_sync, // frame sync pin
  output var logic secondary_frame_sync // secondary sync pin
);
  // both pins idle low between frames
  initial begin
    frame_sync = 1'b0;
    secondary_frame_sync = 1'b0;
  end

  // one rising edge
  // held a few cycles so the synchroniser cannot miss it; slow stretches it
  task automatic pulse(input logic sec, input int slow);
    @(negedge clock);
    if (sec) secondary_frame_sync = 1'b1;
    else frame_sync = 1'b1;
    repeat (2 + slow) @(negedge clock);
    frame_sync = 1'b0;
    secondary_frame_sync = 1'b0;
  endtask : pulse
endmodule : lcm_sync_src
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic hdlc_irq_req = 1'b0;
  logic stat_event = 1'b0;
  wire logic frame_sync;
  wire logic secondary_frame_sync;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic hdlc_irq;
  logic [2:0] line_clk_oe;
  logic [5:0] line_clk_rate;
  logic sub_sel;
  logic pcm02_sel;
  logic pcm13_sel;
  logic [2:0] chan_en;
  logic stat_at_max;
  int errors = 0;
  int comparisons = 0;

  // 10 MHz core clock
  initial begin
    forever #50 clock = ~clock;
  end

  lcm_regs u_lcm_regs (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .frame_sync(frame_sync), .secondary_frame_sync(secondary_frame_sync),
    .hdlc_irq_req(hdlc_irq_req), .stat_event(stat_event), .hdlc_irq(hdlc_irq),
    .line_clk_oe(line_clk_oe), .line_clk_rate(line_clk_rate), .subscriber_pin_select(sub_sel),
    .pcm02_pin_select(pcm02_sel), .pcm13_pin_select(pcm13_sel),
    .generic_hdlc_channel_en(chan_en), .stat_at_max(stat_at_max));
  lcm_sync_src u_lcm_sync_src (.clock(clock), .frame_sync(frame_sync),
    .secondary_frame_sync(secondary_frame_sync));

  // one-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr

  // one-cycle read strobe, answer judged a cycle later
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
  endtask : rd

  task automatic t_defaults;
    rd(lcm_pkg::LCM_OFS_IRQ_MASK, 16'h0000);
    rd(lcm_pkg::LCM_OFS_STAT_LIMIT, 16'h0000);
    rd(lcm_pkg::LCM_OFS_LCLK3_CTRL, 16'h0000);
    rd(lcm_pkg::LCM_OFS_PIN_MUX, 16'h0000);
    rd(16'hD006, 16'h0000);
  endtask : t_defaults

  // every rate code on every line clock, then back to input with rate bits set
  task automatic t_lclk;
    logic [15:0] a;
    for (int i = 0; i < 3; i++) begin
      a = lcm_pkg::LCM_OFS_LCLK1_CTRL + 16'(i);
      for (int r = 0; r < 4; r++) begin
        wr(a, {13'h1FFF, 1'b1, 2'(r)});
        rd(a, {13'h0000, 1'b1, 2'(r)});
        `CHK(line_clk_oe[i], 1'b1)
        `CHK(line_clk_rate[2*i +: 2], 2'(r))
      end
      wr(a, 16'h0003);
      repeat (2) @(negedge clock);
      `CHK(line_clk_oe[i], 1'b0)
      `CHK(line_clk_rate[2*i +: 2], 2'h0)
    end
  endtask : t_lclk

  task automatic t_mux;
    for (int b = 0; b < 3; b++) begin
      wr(lcm_pkg::LCM_OFS_PIN_MUX, 16'h0001 << b);
      @(negedge clock);
      `CHK({pcm13_sel, pcm02_sel, sub_sel}, 3'h1 << b)
      `CHK(chan_en, 3'h1 << b)
    end
  endtask : t_mux

  task automatic t_irq;
    @(negedge clock);
    hdlc_irq_req = 1'b1;
    repeat (2) @(negedge clock);
    `CHK(hdlc_irq, 1'b0)
    wr(lcm_pkg::LCM_OFS_IRQ_MASK, 16'hFFFF);
    rd(lcm_pkg::LCM_OFS_IRQ_MASK, 16'h0001);
    `CHK(hdlc_irq, 1'b1)
    hdlc_irq_req = 1'b0;
    repeat (2) @(negedge clock);
    `CHK(hdlc_irq, 1'b0)
  endtask : t_irq

  // edges one at a time, then both, each cleared by the read
  task automatic t_sync;
    u_lcm_sync_src.pulse(1'b0, 0);
    repeat (4) @(negedge clock);
    rd(lcm_pkg::LCM_OFS_SYNC_STATUS, 16'h0002);
    u_lcm_sync_src.pulse(1'b1, 3);
    repeat (4) @(negedge clock);
    rd(lcm_pkg::LCM_OFS_SYNC_STATUS, 16'h0004);
    u_lcm_sync_src.pulse(1'b0, 0);
    u_lcm_sync_src.pulse(1'b1, 0);
    repeat (4) @(negedge clock);
    rd(lcm_pkg::LCM_OFS_SYNC_STATUS, 16'h0007);
    rd(lcm_pkg::LCM_OFS_SYNC_STATUS, 16'h0000);
  endtask : t_sync

  // frame edge lands in the cycle of a status read: the read sees 0, the bit survives
  task automatic t_sync_clash;
    fork
      u_lcm_sync_src.pulse(1'b0, 0);
      begin
        repeat (3) @(negedge clock);
        rd(lcm_pkg::LCM_OFS_SYNC_STATUS, 16'h0000);
      end
    join
    rd(lcm_pkg::LCM_OFS_SYNC_STATUS, 16'h0002);
  endtask : t_sync_clash

  // count to the limit, clear on a read-armed sync, keep over a bare sync and reset
  task automatic t_stats;
    wr(lcm_pkg::LCM_OFS_STAT_LIMIT, 16'h0005);
    wr(lcm_pkg::LCM_OFS_STAT_COUNT, 16'h0000);
    @(negedge clock);
    stat_event = 1'b1;
    repeat (7) @(negedge clock);
    stat_event = 1'b0;
    rd(lcm_pkg::LCM_OFS_STAT_COUNT, 16'h0005);
    `CHK(stat_at_max, 1'b1)
    u_lcm_sync_src.pulse(1'b0, 0);
    repeat (4) @(negedge clock);
    stat_event = 1'b1;
    repeat (2) @(negedge clock);
    stat_event = 1'b0;
    u_lcm_sync_src.pulse(1'b0, 0);
    repeat (4) @(negedge clock);
    rst = 1'b1;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    rd(lcm_pkg::LCM_OFS_STAT_COUNT, 16'h0002);
  endtask : t_stats

  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence after ten cycles of reset
  initial begin
    repeat (10) @(negedge clock);
    rst = 1'b0;
    t_defaults();
    t_lclk();
    t_mux();
    t_irq();
    t_sync();
    t_sync_clash();
    t_stats();
    tally_and_finish();
  end

  // the run needs well under a thousand cycles; cut a hang short
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
